// ==== ivp_ctrl.v ====
`timescale 1ns/1ps
`include "ivp_map.vh"
// ===========================================================
// priority/vector controller with wishbone registers
module ivp_ctrl (
   input  wire        i_clk,
   input  wire        i_rst_n,
   input  wire        i_ce,
   input  wire        i_cyc,
   input  wire        i_stb,
   input  wire        i_we,
   input  wire [3:0]  i_sel,
   input  wire [5:0]  i_adr,
   input  wire [31:0] i_dat,
   output reg  [31:0] o_dat,
   output reg         o_ack,
   input  wire        i_nmi,
   input  wire [4:0]  i_ext_request_pin,
   input  wire        i_watchdog_interval_overflow,
   input  wire [2:0]  i_tmr0,
   input  wire [2:0]  i_tmr1,
   input  wire [2:0]  i_tmr2,
   input  wire [2:0]  i_tmr3,
   input  wire [2:0]  i_tmr4,
   input  wire [3:0]  i_serial,
   input  wire        i_conversion_end_request,
   output reg         o_req_valid,
   output reg  [5:0]  o_vector,
   output reg  [15:0] o_vector_addr,
   output reg         o_irq
);
   // ===========================================================
   // registers
   reg [7:0]  priority_select_a_r;
   reg [7:0]  priority_select_b_r;
   reg        adv_mode_r;
   reg [1:0]  stat_r;
   reg [1:0]  irq_en_r;
   reg        last_hit_r;
   reg [5:0]  last_vec_r;
   wire       a_bit7 = priority_select_a_r[7];
   wire       a_bit6 = priority_select_a_r[6];
   wire       a_bit5 = priority_select_a_r[5];
   wire       a_bit4 = priority_select_a_r[4];
   wire       a_bit3 = priority_select_a_r[3];
   wire       a_bit2 = priority_select_a_r[2];
   wire       a_bit1 = priority_select_a_r[1];
   wire       a_bit0 = priority_select_a_r[0];
   wire       b_bit7 = priority_select_b_r[7];
   wire       b_bit6 = priority_select_b_r[6];
   wire       b_bit3 = priority_select_b_r[3];
   wire       b_bit1 = priority_select_b_r[1];
   // ===========================================================
   // source slots in vector order; the picker relies on this order
   localparam [4:0] SRC_PIN0      = 5'h00;
   localparam [4:0] SRC_PIN1      = 5'h01;
   localparam [4:0] SRC_PIN2      = 5'h02;
   localparam [4:0] SRC_PIN3      = 5'h03;
   localparam [4:0] SRC_PIN4      = 5'h04;
   localparam [4:0] SRC_WDT       = 5'h05;
   localparam [4:0] SRC_T0A       = 5'h06;
   localparam [4:0] SRC_T0B       = 5'h07;
   localparam [4:0] SRC_T0V       = 5'h08;
   localparam [4:0] SRC_T1A       = 5'h09;
   localparam [4:0] SRC_T1B       = 5'h0A;
   localparam [4:0] SRC_T1V       = 5'h0B;
   localparam [4:0] SRC_T2A       = 5'h0C;
   localparam [4:0] SRC_T2B       = 5'h0D;
   localparam [4:0] SRC_T2V       = 5'h0E;
   localparam [4:0] SRC_T3A       = 5'h0F;
   localparam [4:0] SRC_T3B       = 5'h10;
   localparam [4:0] SRC_T3V       = 5'h11;
   localparam [4:0] SRC_T4A       = 5'h12;
   localparam [4:0] SRC_T4B       = 5'h13;
   localparam [4:0] SRC_T4V       = 5'h14;
   localparam [4:0] SRC_RX_ERR    = 5'h15;
   localparam [4:0] SRC_RX_FULL   = 5'h16;
   localparam [4:0] SRC_TX_EMPTY  = 5'h17;
   localparam [4:0] SRC_TX_END    = 5'h18;
   localparam [4:0] SRC_ADC       = 5'h19;

   // ===========================================================
   // request and level per slot
   // requests are levels held by the sources until cleared there, so
   // losers stay pending with no storage here
   wire [`NUM_SRC-1:0] req;
   wire [`NUM_SRC-1:0] lvl;

   // external pins
   assign req[SRC_PIN0]     = i_ext_request_pin[0];
   assign req[SRC_PIN1]     = i_ext_request_pin[1];
   assign req[SRC_PIN2]     = i_ext_request_pin[2];
   assign req[SRC_PIN3]     = i_ext_request_pin[3];
   assign req[SRC_PIN4]     = i_ext_request_pin[4];
   // watchdog
   assign req[SRC_WDT]      = i_watchdog_interval_overflow;
   // timer 0
   assign req[SRC_T0A]      = i_tmr0[0];
   assign req[SRC_T0B]      = i_tmr0[1];
   assign req[SRC_T0V]      = i_tmr0[2];
   // timer 1
   assign req[SRC_T1A]      = i_tmr1[0];
   assign req[SRC_T1B]      = i_tmr1[1];
   assign req[SRC_T1V]      = i_tmr1[2];
   // timer 2
   assign req[SRC_T2A]      = i_tmr2[0];
   assign req[SRC_T2B]      = i_tmr2[1];
   assign req[SRC_T2V]      = i_tmr2[2];
   // timer 3
   assign req[SRC_T3A]      = i_tmr3[0];
   assign req[SRC_T3B]      = i_tmr3[1];
   assign req[SRC_T3V]      = i_tmr3[2];
   // timer 4
   assign req[SRC_T4A]      = i_tmr4[0];
   assign req[SRC_T4B]      = i_tmr4[1];
   assign req[SRC_T4V]      = i_tmr4[2];
   // serial port
   assign req[SRC_RX_ERR]   = i_serial[0];
   assign req[SRC_RX_FULL]  = i_serial[1];
   assign req[SRC_TX_EMPTY] = i_serial[2];
   assign req[SRC_TX_END]   = i_serial[3];
   // conversion end
   assign req[SRC_ADC]      = i_conversion_end_request;

   // levels: one select bit per group, nmi has none
   // pins 3 and 4 share one bit
   assign lvl[SRC_PIN0]     = a_bit7;
   assign lvl[SRC_PIN1]     = a_bit6;
   assign lvl[SRC_PIN2]     = a_bit5;
   assign lvl[SRC_PIN3]     = a_bit4;
   assign lvl[SRC_PIN4]     = a_bit4;
   // watchdog
   assign lvl[SRC_WDT]      = a_bit3;
   // timer 0
   assign lvl[SRC_T0A]      = a_bit2;
   assign lvl[SRC_T0B]      = a_bit2;
   assign lvl[SRC_T0V]      = a_bit2;
   // timer 1
   assign lvl[SRC_T1A]      = a_bit1;
   assign lvl[SRC_T1B]      = a_bit1;
   assign lvl[SRC_T1V]      = a_bit1;
   // timer 2
   assign lvl[SRC_T2A]      = a_bit0;
   assign lvl[SRC_T2B]      = a_bit0;
   assign lvl[SRC_T2V]      = a_bit0;
   // timer 3
   assign lvl[SRC_T3A]      = b_bit7;
   assign lvl[SRC_T3B]      = b_bit7;
   assign lvl[SRC_T3V]      = b_bit7;
   // timer 4
   assign lvl[SRC_T4A]      = b_bit6;
   assign lvl[SRC_T4B]      = b_bit6;
   assign lvl[SRC_T4V]      = b_bit6;
   // serial port, receive and transmit share one bit
   assign lvl[SRC_RX_ERR]   = b_bit3;
   assign lvl[SRC_RX_FULL]  = b_bit3;
   assign lvl[SRC_TX_EMPTY] = b_bit3;
   assign lvl[SRC_TX_END]   = b_bit3;
   // conversion end
   assign lvl[SRC_ADC]      = b_bit1;

   // ===========================================================
   // winner search
   wire        hit;
   wire [5:0]  pick_vec;
   ivp_pick ivp_pick_i (
      .i_req (req),
      .i_lvl (lvl),
      .o_hit (hit),
      .o_vec (pick_vec)
   );

   // nmi has no select bit and beats every level
   wire        win_hit = i_nmi | hit;
   wire [5:0]  win_vec = i_nmi ? `VEC_NMI : pick_vec;

   // ===========================================================
   // helpers
   // address in table: shift vector by mode, low 16 bits only
   function [15:0] vaddr;
      input [5:0] v;
      input       adv;
      begin
         vaddr = adv ? {8'h00, v, 2'b00} : {9'h000, v, 1'b0};
      end
   endfunction

   // register index match, shared by every write decode
   function reg_sel;
      input [3:0] a;
      input [3:0] r;
      begin
         reg_sel = (a == r);
      end
   endfunction

   // ===========================================================
   // wishbone slave, one-cycle answer, reads return zero off-map
   // writes land on the edge that the master sees ack, not before
   wire        acc  = i_cyc & i_stb & ~o_ack;
   wire        done = i_cyc & i_stb & o_ack;
   wire        wr   = done & i_we & i_sel[0];
   wire [3:0]  idx  = i_adr[5:2];
   wire        wr_pri_a = wr & reg_sel(idx, `ADR_PRI_A);
   wire        wr_pri_b = wr & reg_sel(idx, `ADR_PRI_B);
   wire        wr_mode  = wr & reg_sel(idx, `ADR_MODE);
   wire        wr_en    = wr & reg_sel(idx, `ADR_IRQ_EN);
   wire        wr_clr   = wr & reg_sel(idx, `ADR_IRQ_CLR);

   // ===========================================================
   // status events and interrupt
   wire        new_win  = win_hit & ~last_hit_r;
   wire        nmi_prev = last_hit_r & (last_vec_r == `VEC_NMI);
   wire        new_nmi  = i_nmi & ~nmi_prev;
   wire [`ST_W-1:0] ev;
   assign ev[`ST_WIN] = new_win;
   assign ev[`ST_NMI] = new_nmi;
   // set wins over a clear landing in the same cycle
   wire [`ST_W-1:0] clr      = wr_clr ? i_dat[`ST_W-1:0] : `STAT_RST;
   wire [`ST_W-1:0] stat_nxt = (stat_r & ~clr) | ev;
   wire             irq_nxt  = |(stat_nxt & irq_en_r);

   // ===========================================================
   // read mux
   reg  [31:0] rd_nxt;
   always @* begin
      rd_nxt = `DAT_ZERO;
      case (idx)
         `ADR_PRI_A:  rd_nxt[`REG_W-1:0] = priority_select_a_r;
         `ADR_PRI_B:  rd_nxt[`REG_W-1:0] = priority_select_b_r;
         `ADR_MODE:   rd_nxt[0] = adv_mode_r;
         `ADR_STATUS: rd_nxt[`ST_W-1:0] = stat_r;
         `ADR_IRQ_EN: rd_nxt[`ST_W-1:0] = irq_en_r;
         `ADR_VECTOR: rd_nxt[`VEC_W:0] = {o_req_valid, o_vector};
         `ADR_VADDR:  rd_nxt[`VADDR_W-1:0] = o_vector_addr;
         default:     rd_nxt = `DAT_ZERO;
      endcase
   end

   // ===========================================================
   // registers
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         priority_select_a_r <= `PRI_RST;
      end else if (i_ce && wr_pri_a) begin
         priority_select_a_r <= i_dat[`REG_W-1:0];
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         priority_select_b_r <= `PRI_RST;
      end else if (i_ce && wr_pri_b) begin
         priority_select_b_r <= i_dat[`REG_W-1:0];
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         adv_mode_r <= `MODE_RST;
      end else if (i_ce && wr_mode) begin
         adv_mode_r <= i_dat[0];
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         irq_en_r <= `STAT_RST;
      end else if (i_ce && wr_en) begin
         irq_en_r <= i_dat[`ST_W-1:0];
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         stat_r <= `STAT_RST;
      end else if (i_ce) begin
         stat_r <= stat_nxt;
      end
   end

   // taken from next status so a clear drops the line without a lag
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
      end else if (i_ce) begin
         o_irq <= irq_nxt;
      end
   end

   // ===========================================================
   // bus answer
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_ack <= 1'b0;
      end else if (i_ce) begin
         o_ack <= acc;
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_dat <= `DAT_ZERO;
      end else if (i_ce) begin
         o_dat <= acc ? rd_nxt : `DAT_ZERO;
      end
   end

   // ===========================================================
   // previous winner, used to spot new events
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         last_hit_r <= 1'b0;
      end else if (i_ce) begin
         last_hit_r <= win_hit;
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         last_vec_r <= `VEC_NONE;
      end else if (i_ce) begin
         last_vec_r <= win_vec;
      end
   end

   // ===========================================================
   // vector outputs to the core, one cycle behind the requests
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_req_valid <= 1'b0;
      end else if (i_ce) begin
         o_req_valid <= win_hit;
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_vector <= `VEC_NONE;
      end else if (i_ce) begin
         o_vector <= win_hit ? win_vec : `VEC_NONE;
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_vector_addr <= `VADDR_ZERO;
      end else if (i_ce) begin
         o_vector_addr <= win_hit ? vaddr(win_vec, adv_mode_r)
                                  : `VADDR_ZERO;
      end
   end
endmodule

// ==== ivp_map.vh ====
// Contract
// - default rank: lower vector number wins; nmi 7 highest, 60 lowest
// - select registers reorder all sources except nmi, which stays on top
// - after reset the plain vector-number order applies
// - vector at 4x number in advanced mode, 2x in normal; low 16 bits
// - pins 0..4 at vectors 12..16; bits a7,a6,a5; pins 3 and 4 share a4
// - watchdog overflow vector 20 under a3; other gaps reserved, no source
// - timer 0 a, b, overflow at 24..26 under a2
// - timer 1 a, b, overflow at 28..30 under a1
// - timer 2 a, b, overflow at 32..34 under a0
// - timer 3 a, b, overflow at 36..38 under b7
// - timer 4 a, b, overflow at 40..42 under b6
// - serial rx error and rx full at 52, 53 under b3
// - serial tx empty, tx end at 54, 55 under b3; conversion end 60, b1
// - select bit 0 is level low, 1 is level high; bits reset to 0
// - equal level ties fall back to vector order; losers stay pending
`ifndef IVP_MAP_VH
`define IVP_MAP_VH
// ===========================================================
// register map (word indices; byte address is four times the index)
`define ADR_PRI_A      4'h0
`define ADR_PRI_B      4'h1
`define ADR_MODE       4'h2
`define ADR_STATUS     4'h3
`define ADR_IRQ_EN     4'h4
`define ADR_IRQ_CLR    4'h5
`define ADR_VECTOR     4'h6
`define ADR_VADDR      4'h7
// ===========================================================
// reset values
`define PRI_RST        8'h00
`define MODE_RST       1'b0
`define STAT_RST       2'h0
// ===========================================================
// status bits
`define ST_WIN         0
`define ST_NMI         1
`define ST_W           2
// ===========================================================
// vector numbers
`define VEC_NMI        6'h07
`define VEC_PIN0       6'h0C
`define VEC_WDT        6'h14
`define VEC_TMR0       6'h18
`define VEC_TMR1       6'h1C
`define VEC_TMR2       6'h20
`define VEC_TMR3       6'h24
`define VEC_TMR4       6'h28
`define VEC_SER        6'h34
`define VEC_ADC        6'h3C
`define VEC_NONE       6'h00
`define NUM_SRC        26
// ===========================================================
// widths and idle values
`define REG_W          8
`define VEC_W          6
`define VADDR_W        16
`define DAT_ZERO       32'h00000000
`define VADDR_ZERO     16'h0000
`endif

// ==== ivp_pick.v ====
`timescale 1ns/1ps
`include "ivp_map.vh"
// ===========================================================
// combinational winner search over the 26 sources
module ivp_pick (
   input  wire [`NUM_SRC-1:0] i_req,
   input  wire [`NUM_SRC-1:0] i_lvl,
   output reg         o_hit,
   output reg  [5:0]  o_vec
);
   // source index to vector number
   function [5:0] vec_of;
      input [4:0] k;
      begin
         if (k < 5'd5)
            vec_of = `VEC_PIN0 + {1'b0, k};
         else if (k == 5'd5)
            vec_of = `VEC_WDT;
         else if (k < 5'd9)
            vec_of = `VEC_TMR0 + {1'b0, k} - 6'h06;
         else if (k < 5'd12)
            vec_of = `VEC_TMR1 + {1'b0, k} - 6'h09;
         else if (k < 5'd15)
            vec_of = `VEC_TMR2 + {1'b0, k} - 6'h0C;
         else if (k < 5'd18)
            vec_of = `VEC_TMR3 + {1'b0, k} - 6'h0F;
         else if (k < 5'd21)
            vec_of = `VEC_TMR4 + {1'b0, k} - 6'h12;
         else if (k < 5'd25)
            vec_of = `VEC_SER + {1'b0, k} - 6'h15;
         else
            vec_of = `VEC_ADC;
      end
   endfunction
   integer j;
   reg     hi_hit;
   reg     lo_hit;
   reg [5:0] hi_vec;
   reg [5:0] lo_vec;
   // index order equals vector order, so scanning downward leaves the
   // lowest-numbered requester in each level
   always @* begin
      hi_hit = 1'b0;
      lo_hit = 1'b0;
      hi_vec = `VEC_NONE;
      lo_vec = `VEC_NONE;
      for (j = `NUM_SRC - 1; j >= 0; j = j - 1) begin
         if (i_req[j] && i_lvl[j]) begin
            hi_hit = 1'b1;
            hi_vec = vec_of(j[4:0]);
         end
         if (i_req[j] && !i_lvl[j]) begin
            lo_hit = 1'b1;
            lo_vec = vec_of(j[4:0]);
         end
      end
      o_hit = hi_hit | lo_hit;
      o_vec = hi_hit ? hi_vec : lo_vec;
   end
endmodule

// ==== ivp_ctrl_monitor.sv ====
`timescale 1ns/1ps
// ===========================================================
// port checks of the vector controller
module ivp_ctrl_monitor (
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   input wire logic        i_ce,
   input wire logic        i_cyc,
   input wire logic        i_stb,
   input wire logic        i_nmi,
   input wire logic        o_ack,
   input wire logic        o_req_valid,
   input wire logic [5:0]  o_vector,
   input wire logic [15:0] o_vector_addr
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   chk_ack_follows_req: assert property (
      i_cyc && i_stb && !o_ack && i_ce |=> o_ack) else $error("no ack");
   chk_ack_one_pulse: assert property (
      o_ack |=> !o_ack) else $error("ack held");
   chk_ack_needs_req: assert property (
      $rose(o_ack) |-> $past(i_cyc && i_stb)) else $error("stray ack");
   chk_nmi_on_top: assert property (
      i_ce && i_nmi |=> o_req_valid && o_vector == 6'h07)
      else $error("nmi lost");
   chk_addr_scaled: assert property (
      o_req_valid |-> o_vector_addr == {9'h000, o_vector, 1'b0} ||
                      o_vector_addr == {8'h00, o_vector, 2'b00})
      else $error("bad vector address");
   chk_idle_zero: assert property (
      !o_req_valid |-> o_vector == 6'h00 && o_vector_addr == 16'h0000)
      else $error("idle vector not zero");
   chk_no_reserved: assert property (
      o_req_valid |-> !(o_vector inside {[6'h11:6'h13], [6'h15:6'h17],
         6'h1B, 6'h1F, 6'h23, 6'h27, [6'h2B:6'h33], [6'h38:6'h3B]}))
      else $error("reserved vector given");
   // reset itself is the cause here, so this one is never disabled
   chk_reset_clears: assert property (disable iff (1'b0)
      !i_rst_n |=> !o_req_valid && o_vector == 6'h00)
      else $error("reset left a vector");
endmodule

// ==== ivp_core_model.sv ====
`timescale 1ns/1ps
// ===========================================================
// processor core: takes the vector shown while valid
module ivp_core_model (
   input  wire logic       i_clk,
   input  wire logic       i_valid,
   input  wire logic [5:0] i_vector,
   output logic      [5:0] o_taken
);
   // the core never pushes back, so the controller cannot stall
   always_ff @(posedge i_clk) if (i_valid) o_taken <= i_vector;
endmodule

// ==== tb_ivp_ctrl.sv ====
`timescale 1ns/1ps
// ===========================================================
// bench: bus driver notes reads, watcher compares
module tb_ivp_ctrl;
   logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, md = 0;
   logic        ce = 1;
   logic [5:0]  adr = 6'h00;
   logic [31:0] wd = 32'h0;
   logic [26:0] rq = 27'h0;
   logic [7:0]  pa, pb;
   wire  [31:0] rd;
   wire  [15:0] va;
   wire  [5:0]  vec, taken;
   wire         ack, vld, irq;
   logic [31:0] q[$];
   int          n_errors = 0, total_checks = 0;
   ivp_ctrl ivp_ctrl_i (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
      .i_cyc(cyc), .i_stb(stb), .i_we(we), .i_sel(4'hF), .i_adr(adr),
      .i_dat(wd), .o_dat(rd), .o_ack(ack), .i_nmi(rq[0]),
      .i_ext_request_pin(rq[5:1]), .i_watchdog_interval_overflow(rq[6]),
      .i_tmr0(rq[9:7]), .i_tmr1(rq[12:10]), .i_tmr2(rq[15:13]),
      .i_tmr3(rq[18:16]), .i_tmr4(rq[21:19]), .i_serial(rq[25:22]),
      .i_conversion_end_request(rq[26]), .o_req_valid(vld),
      .o_vector(vec), .o_vector_addr(va), .o_irq(irq));
   ivp_core_model ivp_core_model_i (.i_clk(clk), .i_valid(vld),
      .i_vector(vec), .o_taken(taken));
   initial forever #2.5 clk = ~clk;
   task automatic chk(input string n, input logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic bus(input [3:0] i, input w, input [31:0] d);
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= {i, 2'b00};
      wd <= d;
      do @(posedge clk); while (ack !== 1'b1);
      cyc <= 0;
      stb <= 0;
   endtask
   task automatic rdx(input [3:0] i, input [31:0] e);
      q.push_back(e);
      bus(i, 0, 0);
   endtask
   // level of a source index, sources kept in vector order
   function automatic logic lvl(int k);
      if (k <= 3) return pa[8-k];
      if (k <= 5) return pa[4];
      if (k <= 15) return pa[(15-k)/3];
      if (k <= 21) return pb[7-(k-16)/3];
      return k <= 25 ? pb[3] : pb[1];
   endfunction
   function automatic logic [5:0] vof(int k);
      if (k == 0) return 7;
      if (k <= 5) return 11 + k;
      if (k == 6) return 20;
      if (k <= 21) return 24 + (k-7)/3*4 + (k-7)%3;
      return k <= 25 ? 30 + k : 60;
   endfunction
   // low level first, then high level overwrites; nmi beats all
   function automatic logic [5:0] win();
      logic [5:0] v = 0;
      for (int l = 0; l < 2; l++)
         for (int k = 26; k > 0; k--) if (rq[k] && lvl(k) == l) v = vof(k);
      if (rq[0]) v = 7;
      return v;
   endfunction
   always @(posedge clk) if (ack === 1'b1 && !we)
      chk("read data", rd, q.pop_front());
   initial begin
      #100000;
      n_errors++;
      end_of_test;
   end
   initial begin
      logic [5:0] v;
      void'($urandom(75));
      pa = 0;
      pb = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1;
      rdx(0, 0);
      rdx(1, 0);
      rdx(9, 0);
      // single sources in default order, then random mixes and levels
      for (int i = 0; i < 60; i++) begin
         rq <= i < 27 ? 27'h1 << i
                      : i == 27 ? 27'h0 : 27'($urandom & $urandom);
         pa = i < 27 ? 8'h00 : 8'($urandom);
         pb = i < 27 ? 8'h00 : 8'($urandom);
         md = i[0];
         bus(0, 1, {24'h0, pa});
         bus(1, 1, {24'h0, pb});
         bus(2, 1, {31'h0, md});
         v = win();
         rdx(6, {25'h0, v != 0, v});
         rdx(7, md ? {24'h0, v, 2'b00} : {25'h0, v, 1'b0});
         if (v != 0) chk("core taken", taken, v);
      end
      rq <= 27'h0;
      bus(4, 1, 1);
      bus(5, 1, 3);
      rdx(3, 0);
      rq <= 27'h2;
      repeat (3) @(posedge clk);
      rdx(3, 1);
      chk("irq raised", irq, 1);
      bus(4, 1, 0);
      repeat (2) @(posedge clk);
      chk("irq masked", irq, 0);
      // nmi replacing the pin request in the same cycle sets only the nmi status bit
      bus(4, 1, 3);
      bus(5, 1, 3);
      rq <= 27'h1;
      repeat (3) @(posedge clk);
      rdx(3, 2);
      chk("irq on nmi", irq, 1);
      // clock enable low freezes the vector path
      rq <= 27'h0;
      repeat (3) @(posedge clk);
      ce <= 0;
      rq <= 27'h4;
      repeat (3) @(posedge clk);
      chk("frozen vector", vec, 0);
      ce <= 1;
      repeat (2) @(posedge clk);
      chk("thawed vector", vec, 13);
      end_of_test;
   end
endmodule
bind ivp_ctrl ivp_ctrl_monitor ivp_ctrl_monitor_i (.i_clk(i_clk),
   .i_rst_n(i_rst_n), .i_ce(i_ce), .i_cyc(i_cyc), .i_stb(i_stb),
   .i_nmi(i_nmi), .o_ack(o_ack), .o_req_valid(o_req_valid),
   .o_vector(o_vector), .o_vector_addr(o_vector_addr));
